// File: tap_device.sv
// device end: tap state machine, instruction and data registers, debug hooks
// assumes tck/tms/tdi arrive asynchronously and are oversampled by i_mclk
// Function
// RULE1 - only four test pins, no reset pin
// RULE2 - fuse off: ordinary pins, machine held reset
// RULE3 - enabled port pulls test inputs high
// RULE4 - data-out released outside shift states
// RULE5 - far end pulls up data-out line
// RULE6 - sixteen states stepped by mode-select
// RULE7 - power-on reset starts Test-Logic-Reset
// RULE8 - least significant bit shifts first
// RULE9 - controller enters Shift-IR with 1,1,0,0
// RULE10 - last instruction bit taken leaving Shift-IR
// RULE11 - instruction capture shifts out 0x01
// RULE12 - instruction applied only in Update-IR
// RULE13 - 1,0,0 reaches Shift-DR, selected register
// RULE14 - captured parallel inputs shift out
// RULE15 - latched outputs change only in Update-DR; access flag also clears whenever debug is disabled
// RULE16 - five high mode-selects reach reset
// RULE17 - break unit: flow, step, four points
// RULE18 - debug needs both fuses, no locks
// RULE19 - opcodes 8 to B are debug ops
// RULE20 - cpu write sets dirty; read shows it
// RULE21 - debugger clears dirty after reading
// RULE22 - shared address reaches channel only when enabled
// RULE23 - data-out changes on falling test clock
// RULE24 - bypass cleared leaving Capture-DR
`timescale 1ns/1ps
`default_nettype none

module tap_device
    import tap_pkg::*;
(
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_b,
    // test port link
    tap_link_if.dev         link,
    // fuses and lock bits
    input  wire logic       i_port_enable_fuse,
    input  wire logic       i_debug_enable_fuse,
    input  wire logic [1:0] i_lock_bits,
    // data-out pin as ordinary port pin
    input  wire logic       i_pin_out,
    input  wire logic       i_pin_oe,
    // cpu register port
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // debug status
    output logic [3:0]      o_instr,
    output logic            o_port_active,
    output logic            o_debug_active,
    output logic            o_break_flow,
    output logic            o_break_step,
    output logic [2:0]      o_break_combo,
    output logic [3:0]      o_pin_in
);
    import tap_pkg::*;

    // =====================================================
    // next state of the test port machine
    function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
        case (s)
            TLR:      tap_next = m ? TLR      : IDLE;
            IDLE:     tap_next = m ? SEL_DR   : IDLE;
            SEL_DR:   tap_next = m ? SEL_IR   : CAP_DR;
            CAP_DR:   tap_next = m ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: tap_next = m ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: tap_next = m ? UPD_DR   : PAUSE_DR;
            PAUSE_DR: tap_next = m ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: tap_next = m ? UPD_DR   : SHIFT_DR;
            UPD_DR:   tap_next = m ? SEL_DR   : IDLE;
            SEL_IR:   tap_next = m ? TLR      : CAP_IR;
            CAP_IR:   tap_next = m ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: tap_next = m ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: tap_next = m ? UPD_IR   : PAUSE_IR;
            PAUSE_IR: tap_next = m ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: tap_next = m ? UPD_IR   : SHIFT_IR;
            UPD_IR:   tap_next = m ? SEL_DR   : IDLE;
            default:  tap_next = TLR;
        endcase
    endfunction : tap_next

    // =====================================================
    // pin synchronisers; stage 1 feeds only stage 2
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       tck_prev_q;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // idle levels: clock low, pulled-up inputs high, so no false edge after reset
            sync1_q    <= 3'h3;
            sync2_q    <= 3'h3;
            tck_prev_q <= 1'b0;
        end else begin
            sync1_q    <= {link.tck, link.tms, link.tdi};
            sync2_q    <= sync1_q;
            tck_prev_q <= sync2_q[2];
        end
    end

    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_rise;
    logic tck_fall;

    assign tck_s    = sync2_q[2];
    assign tms_s    = sync2_q[1];
    assign tdi_s    = sync2_q[0];
    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;

    // =====================================================
    // state
    tap_state_t state_q, state_d;
    logic [3:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic [7:0] dr_sh_q, dr_sh_d;
    logic [7:0] chan_q, chan_d, normal_q, normal_d, ctrl_q, ctrl_d, rdata_d;
    logic       dirty_q, dirty_d, access_q, access_d;
    logic       flow_q, flow_d, step_q, step_d;
    logic [2:0] combo_q, combo_d;
    logic       tdo_q, tdo_d, oe_q, oe_d, pull_q, pull_d;
    logic       port_en, dbg_en, sel_bypass, chan_hit;
    logic [3:0] pin_in_q;

    // =====================================================
    // next values
    always_comb begin
        // port enable needs the fuse and a clear disable bit
        port_en    = i_port_enable_fuse & ~ctrl_q[`CTRL_DISABLE_BIT];
        dbg_en     = port_en & i_debug_enable_fuse & ~(|i_lock_bits);          // RULE18
        sel_bypass = ~(dbg_en && ir_q >= `IR_DEBUG_OP_A && ir_q <= `IR_DEBUG_OP_D); // RULE19
        chan_hit   = (i_addr == `REG_CHAN_OFS) & i_debug_enable_fuse & access_q & dbg_en; // RULE22
        state_d    = state_q;
        ir_sh_d    = ir_sh_q;
        ir_d       = ir_q;
        dr_sh_d    = dr_sh_q;
        chan_d     = chan_q;
        normal_d   = normal_q;
        ctrl_d     = ctrl_q;
        dirty_d    = dirty_q;
        access_d   = access_q;
        flow_d     = flow_q;
        step_d     = step_q;
        combo_d    = combo_q;
        tdo_d      = tdo_q;
        oe_d       = oe_q;
        pull_d     = port_en;                                                  // RULE3
        rdata_d    = 8'h00;

        if (!port_en) begin
            state_d = TLR;                                                     // RULE2
            ir_d    = `IR_DEFAULT;
            tdo_d   = i_pin_out;
            oe_d    = i_pin_oe;
        end else begin
            if (tck_rise) begin
                state_d = tap_next(state_q, tms_s);                            // RULE6 RULE16
                case (state_q)
                    TLR:      ir_d    = `IR_DEFAULT;
                    CAP_IR:   ir_sh_d = `IR_CAPTURE_VALUE;                     // RULE11
                    SHIFT_IR: ir_sh_d = {tdi_s, ir_sh_q[3:1]};                 // RULE8 RULE10
                    UPD_IR:   ir_d    = ir_sh_q;                               // RULE12
                    CAP_DR: begin
                        case (sel_bypass ? 4'h0 : ir_q)                        // RULE14
                            `IR_DEBUG_OP_A: dr_sh_d = {dirty_q, chan_q[6:0]};
                            `IR_DEBUG_OP_B: dr_sh_d = {3'h0, combo_q, step_q, flow_q};
                            `IR_DEBUG_OP_C: dr_sh_d = {7'h00, access_q};
                            `IR_DEBUG_OP_D: dr_sh_d = {4'h0, i_lock_bits, i_debug_enable_fuse, dbg_en};
                            default:        dr_sh_d = 8'h00;                   // RULE24
                        endcase
                    end
                    SHIFT_DR: begin
                        if (sel_bypass) begin
                            dr_sh_d = {7'h00, tdi_s};
                        end else begin
                            dr_sh_d = {tdi_s, dr_sh_q[7:1]};                   // RULE8 RULE13
                        end
                    end
                    UPD_DR: begin
                        case (sel_bypass ? 4'h0 : ir_q)                        // RULE15
                            `IR_DEBUG_OP_A: dirty_d = 1'b0;                    // RULE21
                            `IR_DEBUG_OP_B: begin
                                flow_d = dr_sh_q[`BRK_FLOW_BIT];               // RULE17
                                step_d = dr_sh_q[`BRK_STEP_BIT];
                                if (dr_sh_q[`BRK_COMBO_MSB:`BRK_COMBO_LSB] <= `BRK_COMBO_LAST) begin
                                    combo_d = dr_sh_q[`BRK_COMBO_MSB:`BRK_COMBO_LSB];
                                end
                            end
                            `IR_DEBUG_OP_C: access_d = dr_sh_q[`CHAN_ACCESS_BIT];
                            default: ;
                        endcase
                    end
                    default: ;
                endcase
            end
            // drive out on the falling edge so the controller samples at the next rise
            if (tck_fall) begin                                                // RULE23
                oe_d  = (state_q == SHIFT_IR) || (state_q == SHIFT_DR);        // RULE4
                tdo_d = (state_q == SHIFT_IR) ? ir_sh_q[0] : dr_sh_q[0];
            end
        end
        if (!dbg_en) begin
            access_d = 1'b0;
        end

        // cpu side
        if (i_wr) begin
            if (i_addr == `REG_CTRL_OFS) begin
                ctrl_d = i_wdata & (8'h01 << `CTRL_DISABLE_BIT);
            end else if (chan_hit) begin
                chan_d  = i_wdata;
                dirty_d = 1'b1;                                                // RULE20
            end else if (i_addr == `REG_CHAN_OFS) begin
                normal_d = i_wdata;
            end
        end
        if (i_rd) begin
            if (i_addr == `REG_CTRL_OFS) begin
                rdata_d = ctrl_q;
            end else if (chan_hit) begin
                rdata_d = {dirty_q, chan_q[6:0]};                              // RULE20
            end else if (i_addr == `REG_CHAN_OFS) begin
                rdata_d = normal_q;
            end
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q  <= TLR;                                                   // RULE7
            ir_sh_q  <= 4'h0;
            ir_q     <= `IR_DEFAULT;
            dr_sh_q  <= 8'h00;
            chan_q   <= `CHAN_RESET;
            normal_q <= 8'h00;
            ctrl_q   <= `CTRL_RESET;
            dirty_q  <= 1'b0;
            access_q <= 1'b0;
            flow_q   <= 1'b0;
            step_q   <= 1'b0;
            combo_q  <= 3'h0;
            tdo_q    <= 1'b1;
            oe_q     <= 1'b0;
            pull_q   <= 1'b0;
            o_rdata  <= 8'h00;
            pin_in_q <= 4'h0;
        end else begin
            state_q  <= state_d;
            ir_sh_q  <= ir_sh_d;
            ir_q     <= ir_d;
            dr_sh_q  <= dr_sh_d;
            chan_q   <= chan_d;
            normal_q <= normal_d;
            ctrl_q   <= ctrl_d;
            dirty_q  <= dirty_d;
            access_q <= access_d;
            flow_q   <= flow_d;
            step_q   <= step_d;
            combo_q  <= combo_d;
            tdo_q    <= tdo_d;
            oe_q     <= oe_d;
            pull_q   <= pull_d;
            o_rdata  <= rdata_d;
            pin_in_q <= {tck_s, tms_s, tdi_s, 1'b0};
        end
    end

    // =====================================================
    // outputs; only four pins exist, no test reset input    // RULE1
    assign link.tdo_out   = tdo_q;
    assign link.tdo_oe    = oe_q;
    assign link.pullup_en = pull_q;
    assign o_instr        = ir_q;
    assign o_port_active  = pull_q;
    assign o_debug_active = access_q;
    assign o_break_flow   = flow_q;
    assign o_break_step   = step_q;
    assign o_break_combo  = combo_q;
    assign o_pin_in       = pin_in_q;

endmodule : tap_device

`default_nettype wire

// File: tap_consts.svh
// constants of the four-pin test port and its debug hooks
// assumes inclusion by the package and both ends of the link
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

// =====================================================
// instruction codes
`define IR_WIDTH          4
`define IR_CAPTURE_VALUE  4'h1
`define IR_DEFAULT        4'hF
`define IR_DEBUG_OP_A     4'h8
`define IR_DEBUG_OP_B     4'h9
`define IR_DEBUG_OP_C     4'hA
`define IR_DEBUG_OP_D     4'hB

// =====================================================
// data register layout
`define DR_WIDTH          8
`define BRK_FLOW_BIT      0
`define BRK_STEP_BIT      1
`define BRK_COMBO_LSB     2
`define BRK_COMBO_MSB     4
`define BRK_COMBO_LAST    3'h4
`define CHAN_ACCESS_BIT   0

// =====================================================
// cpu register map
`define REG_CTRL_OFS      2'h0
`define REG_CHAN_OFS      2'h1
`define CTRL_DISABLE_BIT  7
`define CTRL_RESET        8'h00
`define CHAN_RESET        8'h00

// =====================================================
// timing: host test clock half period in i_mclk cycles
`define TCK_HALF_CYC      5'h0C
`define RESET_TMS_ONES    5

`endif

// File: tap_pkg.sv
// types shared by both ends of the test port link
// assumes tap_consts.svh on the include path
`include "tap_consts.svh"

package tap_pkg;

    typedef enum logic [15:0] {
        TLR        = 16'h0001,
        IDLE       = 16'h0002,
        SEL_DR     = 16'h0004,
        CAP_DR     = 16'h0008,
        SHIFT_DR   = 16'h0010,
        EXIT1_DR   = 16'h0020,
        PAUSE_DR   = 16'h0040,
        EXIT2_DR   = 16'h0080,
        UPD_DR     = 16'h0100,
        SEL_IR     = 16'h0200,
        CAP_IR     = 16'h0400,
        SHIFT_IR   = 16'h0800,
        EXIT1_IR   = 16'h1000,
        PAUSE_IR   = 16'h2000,
        EXIT2_IR   = 16'h4000,
        UPD_IR     = 16'h8000
    } tap_state_t;

    typedef enum logic [1:0] {
        CMD_RESET  = 2'h0,
        CMD_IR     = 2'h1,
        CMD_DR     = 2'h2
    } host_cmd_t;

    typedef enum logic [1:0] {
        H_IDLE     = 2'h1,
        H_RUN      = 2'h2
    } host_state_t;

endpackage : tap_pkg

// File: tap_link_if.sv
// the four test port wires between debug controller and device
// assumes both ends run on the same i_mclk; the pull-up on the data-out line lives here
`timescale 1ns/1ps
`default_nettype none

interface tap_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_out;
    logic tdo_oe;
    logic pullup_en;
    wire  tdo;

    // released data-out line floats high through the board pull-up
    assign tdo = tdo_oe ? tdo_out : 1'b1;

    modport host (output tck, output tms, output tdi, input tdo);
    modport dev  (input tck, input tms, input tdi, output tdo_out, output tdo_oe, output pullup_en);
endinterface : tap_link_if

`default_nettype wire

// File: tap_host.sv
// controller end: makes the test clock and walks the state machine
// assumes the device starts in Run-Test/Idle for scans; the reset sequence works from any state
`timescale 1ns/1ps
`default_nettype none

module tap_host
    import tap_pkg::*;
(
    // clock and reset
    input  wire logic            i_mclk,
    input  wire logic            i_rst_b,
    // test port link
    tap_link_if.host             link,
    // command port
    input  wire logic            i_start,
    input  wire tap_pkg::host_cmd_t i_cmd,
    input  wire logic [3:0]      i_len,
    input  wire logic [7:0]      i_data,
    output logic                 o_busy,
    output logic                 o_done,
    output logic [7:0]           o_rdata
);
    import tap_pkg::*;

    // =====================================================
    // state
    host_state_t st_q, st_d;
    logic [4:0]  div_q, div_d;
    logic [3:0]  step_q, step_d, nstep_q, nstep_d, sh_lo_q, sh_lo_d, len_q, len_d;
    logic [15:0] tms_q, tms_d, tdi_q, tdi_d;
    logic [7:0]  cap_q, cap_d;
    logic        tck_q, tck_d, tms_o_q, tms_o_d, tdi_o_q, tdi_o_d, done_d, done_q;
    logic        tdo_s1_q, tdo_s2_q;

    // =====================================================
    // next values
    always_comb begin
        st_d    = st_q;
        div_d   = div_q;
        step_d  = step_q;
        nstep_d = nstep_q;
        sh_lo_d = sh_lo_q;
        len_d   = len_q;
        tms_d   = tms_q;
        tdi_d   = tdi_q;
        cap_d   = cap_q;
        tck_d   = tck_q;
        tms_o_d = tms_o_q;
        tdi_o_d = tdi_o_q;
        done_d  = 1'b0;
        case (st_q)
            H_IDLE: begin
                tck_d = 1'b0;
                if (i_start) begin
                    len_d = (i_len == 4'h0) ? 4'h1 : ((i_len > 4'h8) ? 4'h8 : i_len);
                    tdi_d = 16'h0000;
                    case (i_cmd)
                        CMD_IR: begin                                          // RULE9
                            sh_lo_d = 4'h4;
                            tms_d   = (16'h0003 | (16'h0003 << (4'h3 + len_d)));  // RULE10 RULE12
                            tdi_d   = {4'h0, i_data, 4'h0} & ~(16'hFFF0 << len_d);
                            nstep_d = 4'h4 + len_d + 4'h2;
                        end
                        CMD_DR: begin                                          // RULE13
                            sh_lo_d = 4'h3;
                            tms_d   = (16'h0001 | (16'h0003 << (4'h2 + len_d)));
                            tdi_d   = {5'h00, i_data, 3'h0} & ~(16'hFFF8 << len_d);
                            nstep_d = 4'h3 + len_d + 4'h2;
                        end
                        default: begin
                            // five high then one low lands in Run-Test/Idle
                            sh_lo_d = 4'hF;
                            tms_d   = 16'h001F;
                            nstep_d = 4'h6;
                        end
                    endcase
                    // exit, update, then idle: the two bits after the last shift are 1 then 0
                    step_d  = 4'h0;
                    div_d   = 5'h00;
                    cap_d   = 8'h00;
                    tms_o_d = tms_d[0];
                    tdi_o_d = tdi_d[0];
                    st_d    = H_RUN;
                end
            end
            H_RUN: begin
                div_d = div_q + 5'h01;
                if (div_q == `TCK_HALF_CYC - 5'h01) begin
                    div_d = 5'h00;
                    tck_d = ~tck_q;
                    if (!tck_q) begin
                        // rising edge: device data-out settled since its falling edge
                        if (step_q >= sh_lo_q && step_q < sh_lo_q + len_q) begin
                            cap_d = {tdo_s2_q, cap_q[7:1]};                    // RULE8
                        end
                    end else begin
                        step_d = step_q + 4'h1;
                        if (step_q + 4'h1 == nstep_q) begin
                            st_d   = H_IDLE;
                            done_d = 1'b1;
                            cap_d  = cap_q >> (4'h8 - len_q);
                        end else begin
                            tms_o_d = tms_q[step_q + 4'h1];
                            tdi_o_d = tdi_q[step_q + 4'h1];
                        end
                    end
                end
            end
            default: st_d = H_IDLE;
        endcase
    end

    // =====================================================
    // registers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q     <= H_IDLE;
            div_q    <= 5'h00;
            step_q   <= 4'h0;
            nstep_q  <= 4'h0;
            sh_lo_q  <= 4'hF;
            len_q    <= 4'h1;
            tms_q    <= 16'h0000;
            tdi_q    <= 16'h0000;
            cap_q    <= 8'h00;
            tck_q    <= 1'b0;
            tms_o_q  <= 1'b1;
            tdi_o_q  <= 1'b1;
            done_q   <= 1'b0;
            tdo_s1_q <= 1'b1;
            tdo_s2_q <= 1'b1;
        end else begin
            st_q     <= st_d;
            div_q    <= div_d;
            step_q   <= step_d;
            nstep_q  <= nstep_d;
            sh_lo_q  <= sh_lo_d;
            len_q    <= len_d;
            tms_q    <= tms_d;
            tdi_q    <= tdi_d;
            cap_q    <= cap_d;
            tck_q    <= tck_d;
            tms_o_q  <= tms_o_d;
            tdi_o_q  <= tdi_o_d;
            done_q   <= done_d;
            tdo_s1_q <= link.tdo;                                              // RULE5
            tdo_s2_q <= tdo_s1_q;
        end
    end

    assign link.tck = tck_q;
    assign link.tms = tms_o_q;
    assign link.tdi = tdi_o_q;
    assign o_busy   = (st_q == H_RUN);
    assign o_done   = done_q;
    assign o_rdata  = cap_q;

endmodule : tap_host

`default_nettype wire

// File: tap_link_checker.sv
// checker for the four test port wires
// assumes host and device share i_mclk
`timescale 1ns/1ps
`default_nettype none

module tap_link_checker (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // link wires
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo_out,
    input wire logic tdo_oe,
    input wire logic pullup_en,
    input wire logic tdo
);
    logic [2:0] ones_q;
    logic [2:0] ones_d;
    logic       tck_q;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    // =====================================================
    // high mode-selects in a row, saturating so it never wraps
    always_comb begin
        ones_d = ones_q;
        if (tck && !tck_q) begin
            ones_d = !tms ? 3'h0 : (ones_q == 3'h7 ? ones_q : ones_q + 3'h1);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ones_q <= 3'h0;
            tck_q  <= 1'b0;
        end else begin
            ones_q <= ones_d;
            tck_q  <= tck;
        end
    end

    // =====================================================
    // properties
    a_oe_needs_port: assert property (tdo_oe |-> pullup_en) else $error("data-out driven, port off");
    a_oe_rise_low: assert property ($rose(tdo_oe) |-> !tck) else $error("data-out enabled, clock high");
    a_oe_fall_low: assert property ($fell(tdo_oe) |-> !tck) else $error("data-out released, clock high");
    a_tdo_on_fall: assert property (tdo_oe && $changed(tdo_out) |-> !tck) else $error("data-out moved, clock high");
    a_five_ones: assert property (ones_q >= 3'h5 && $fell(tck) |-> ##6 !tdo_oe) else $error("no reset after ones");
    a_tms_on_fall: assert property ($changed(tms) |-> !tck) else $error("mode-select moved, clock high");
    a_tdi_on_fall: assert property ($changed(tdi) |-> !tck) else $error("data-in moved, clock high");
    a_tdo_released: assert property (!tdo_oe |-> tdo) else $error("released line not high");
endmodule : tap_link_checker

`default_nettype wire

// File: tap_controller_debug_port_tb.sv
// bench: host and device joined by the link, cpu port driven here
// assumes the design files and tap_link_checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module tap_controller_debug_port_tb;
    import tap_pkg::*;
    logic i_mclk = 1'b0, i_rst_b = 1'b0, start = 1'b0, wr = 1'b0, rd = 1'b0;
    logic pfuse = 1'b1, dfuse = 1'b1, pact, dact, flow, step, busy, done;
    logic [1:0] lock = 2'h0, addr = 2'h0;
    logic [3:0] len = 4'h1, instr;
    logic [2:0] combo;
    logic [7:0] wdata = 8'h00, hdata = 8'h00, drd, hrd, d;
    host_cmd_t cmd = CMD_RESET;
    int n_fail = 0, checked = 0, cb = 0;

    always #2.5 i_mclk = ~i_mclk;

    tap_link_if tap_link_if_inst ();
    tap_device tap_device_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .link(tap_link_if_inst.dev),
        .i_port_enable_fuse(pfuse), .i_debug_enable_fuse(dfuse), .i_lock_bits(lock), .i_pin_out(1'b0),
        .i_pin_oe(1'b0), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(drd), .o_instr(instr),
        .o_port_active(pact), .o_debug_active(dact), .o_break_flow(flow), .o_break_step(step),
        .o_break_combo(combo), .o_pin_in());
    tap_host tap_host_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .link(tap_link_if_inst.host), .i_start(start),
        .i_cmd(cmd), .i_len(len), .i_data(hdata), .o_busy(busy), .o_done(done), .o_rdata(hrd));
    tap_link_checker tap_link_checker_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .tck(tap_link_if_inst.tck),
        .tms(tap_link_if_inst.tms), .tdi(tap_link_if_inst.tdi), .tdo_out(tap_link_if_inst.tdo_out),
        .tdo_oe(tap_link_if_inst.tdo_oe), .pullup_en(tap_link_if_inst.pullup_en), .tdo(tap_link_if_inst.tdo));

    // =====================================================
    // shared tasks
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic scan(input host_cmd_t c, input logic [3:0] n, input logic [7:0] v);
        @(posedge i_mclk);
        start <= 1'b1;
        cmd <= c;
        len <= n;
        hdata <= v;
        @(posedge i_mclk);
        start <= 1'b0;
        for (int k = 0; k < 4000 && done !== 1'b1; k++) @(negedge i_mclk);
        chk("done", {7'h0, done}, 8'h01);
    endtask : scan

    // read data sampled in the cycle after the strobe
    task automatic cpu(input logic w, input logic [7:0] v);
        @(posedge i_mclk);
        wr <= w;
        rd <= !w;
        addr <= 2'h1;
        wdata <= v;
        @(posedge i_mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge i_mclk);
    endtask : cpu

    task automatic report_and_stop();
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // =====================================================
    // scenarios
    initial begin
        void'($urandom(32'hC8F9BD90));
        repeat (8) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        scan(CMD_RESET, 4'h1, 8'h00);
        chk("port", {7'h0, pact}, 8'h01);
        chk("instr", {4'h0, instr}, 8'h0F);
        d = 8'($urandom);
        scan(CMD_DR, 4'h8, d);
        chk("bypass", hrd, {d[6:0], 1'b0});
        for (int op = 8; op < 12; op++) begin
            scan(CMD_IR, 4'h4, 8'(op));
            chk("ircap", hrd, 8'h01);
            chk("instr", {4'h0, instr}, 8'(op));
        end
        scan(CMD_IR, 4'h4, 8'h09);
        for (int c = 0; c < 6; c++) begin
            d = {3'h0, 3'(c), 2'($urandom)};
            if (c < 5) cb = c;
            scan(CMD_DR, 4'h8, d);
            chk("combo", {5'h0, combo}, 8'(cb));
            if (c < 5) chk("flow", {6'h0, step, flow}, {6'h0, d[1:0]});
        end
        scan(CMD_IR, 4'h4, 8'h0A);
        scan(CMD_DR, 4'h8, 8'h01);
        chk("access", {7'h0, dact}, 8'h01);
        d = 8'($urandom);
        cpu(1'b1, d);
        cpu(1'b0, 8'h00);
        chk("chan", drd, {1'b1, d[6:0]});
        scan(CMD_IR, 4'h4, 8'h08);
        scan(CMD_DR, 4'h8, d);
        chk("opa", hrd, {1'b1, d[6:0]});
        cpu(1'b0, 8'h00);
        chk("clear", drd, {1'b0, d[6:0]});
        scan(CMD_IR, 4'h4, 8'h0B);
        scan(CMD_DR, 4'h5, 8'h00);
        chk("status", hrd, 8'h03);
        lock <= 2'h1;
        repeat (4) @(posedge i_mclk);
        chk("locked", {7'h0, dact}, 8'h00);
        scan(CMD_RESET, 4'h1, 8'h00);
        chk("reset", {4'h0, instr}, 8'h0F);
        pfuse <= 1'b0;
        repeat (4) @(posedge i_mclk);
        chk("portoff", {7'h0, pact}, 8'h00);
        scan(CMD_IR, 4'h4, 8'h08);
        chk("held", {4'h0, instr}, 8'h0F);
        report_and_stop();
    end

    // cut a hang short well past the expected run length
    initial begin
        repeat (40000) @(posedge i_mclk);
        n_fail++;
        report_and_stop();
    end
endmodule : tap_controller_debug_port_tb

`default_nettype wire
